/* cfc_pkg.sv */
// package of constants and types for the cycle and flag control block
package cfc_pkg;

  // instruction classes presented by the decoder
  typedef enum logic [4:0] {
    CFC_OP_OTHER,      // plain single cycle op, no flags
    CFC_OP_JUMP,       // unconditional jump
    CFC_OP_CALL,       // subroutine call
    CFC_OP_IDX,        // indirect memory transfer
    CFC_OP_PCADD,      // computed program counter add
    CFC_OP_RET,        // subroutine return
    CFC_OP_RETI,       // interrupt return
    CFC_OP_ARITH,      // add, addc, sub, subc, inc, dec
    CFC_OP_FLAG_POP,   // flag restore from the stack
    CFC_OP_CMP_SKIP,   // compare and skip
    CFC_OP_INCDEC_SKIP, // increment or decrement and skip
    CFC_OP_TEST_CLEAR_SKIP, // test bit clear and skip
    CFC_OP_TEST_SET_SKIP,   // test bit set and skip
    CFC_OP_LOGIC,      // and, or, xor, not, neg, move into accumulator
    CFC_OP_SHIFT,      // shifts, rotates, carry swap
    CFC_OP_BIT_MEM     // set, clear bit of data ram
  } cfc_op_e;

  // flag positions in the status byte
  localparam int unsigned CFC_ZERO_BIT = 0;
  localparam int unsigned CFC_CARRY_BIT = 1;
  localparam int unsigned CFC_AUX_BIT = 2;
  localparam int unsigned CFC_OVF_BIT = 3;

  // flag update masks
  localparam logic [3:0] CFC_MASK_ALL = 4'hf;
  localparam logic [3:0] CFC_MASK_ZERO = 4'h1;
  localparam logic [3:0] CFC_MASK_CARRY = 4'h2;
  localparam logic [3:0] CFC_MASK_NONE = 4'h0;
  localparam logic [3:0] CFC_FLAGS_RST = 4'h0;

  // machine cycle counts
  localparam logic [1:0] CFC_CYC_ONE = 2'h1;
  localparam logic [1:0] CFC_CYC_TWO = 2'h2;

  // bit addressable ram window
  localparam logic [7:0] CFC_BIT_RAM_LO = 8'h00;
  localparam logic [7:0] CFC_BIT_RAM_HI = 8'h3f;

  // stack pointer step of a call
  localparam logic [7:0] CFC_SP_STEP = 8'h02;
  localparam logic [7:0] CFC_SP_RST = 8'h00;

endpackage : cfc_pkg

/* cfc_if.sv */
// interface carrying flag results from the main block to the flag store
`timescale 1ns/10ps
interface cfc_if;
  logic upd;          // apply an update this cycle
  logic [3:0] mask;   // which flags change
  logic [3:0] value;  // new flag values
  logic [3:0] flags;  // current flags
  modport ctl (output upd, output mask, output value, input flags);
  modport store (input upd, input mask, input value, output flags);
endinterface : cfc_if

/* cfc_flag_store.sv */
// masked status flag register
`timescale 1ns/10ps
module cfc_flag_store
  import cfc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  cfc_if.store fl
);

  logic [3:0] flags_reg; // zero, carry, aux carry, overflow
  logic [3:0] flags_next;

  // only masked bits take the new value
  assign flags_next = fl.upd ? ((flags_reg & ~fl.mask) | (fl.value & fl.mask)) : flags_reg;

  // flag register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_reg <= CFC_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign fl.flags = flags_reg;

endmodule : cfc_flag_store

/* cfc_core_ctl.sv */
// cycle, flag mask, bit range and stack control of the core
`timescale 1ns/10ps
module cfc_core_ctl
  import cfc_pkg::*;
#(
  parameter int PC_W = 12 // program counter width
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic instr_valid,
  input cfc_op_e instr_op,
  input wire logic [7:0] cmp_a,
  input wire logic [7:0] cmp_b,
  input wire logic [7:0] bit_addr,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] bit_data,
  input wire logic [PC_W-1:0] pc_cur,
  input wire logic [PC_W-1:0] target_pc,
  input wire logic [PC_W-1:0] stack_pc,
  input wire logic [3:0] alu_flags,
  input wire logic gie_set,
  input wire logic gie_clr,
  output logic busy,
  output logic [1:0] cycles,
  output logic skip_next,
  output logic bit_err,
  output logic [3:0] flags,
  output logic stack_we,
  output logic [7:0] stack_addr,
  output logic [PC_W-1:0] stack_wdata,
  output logic [7:0] stack_pointer,
  output logic pc_load,
  output logic [PC_W-1:0] pc_new,
  output logic gie
);

  // refuse program counter widths that the stack word cannot carry
  if (PC_W < 2 || PC_W > 16) begin : g_bad_pc_w
    $error("pc width out of range");
  end

  // states of the two cycle sequencer
  typedef enum logic {CFC_S_FIRST, CFC_S_SECOND} cfc_state_e;
  cfc_state_e state_reg, state_next;

  cfc_if fl();

  cfc_flag_store u_flags (
    .mclk(mclk),
    .rst(rst),
    .fl(fl)
  );

  // bit address inside the window
  function automatic logic in_bit_ram(input logic [7:0] a);
    in_bit_ram = (a >= CFC_BIT_RAM_LO) && (a <= CFC_BIT_RAM_HI);
  endfunction : in_bit_ram

  // decoded conditions
  wire logic is_bit_op = (instr_op == CFC_OP_BIT_MEM) || (instr_op == CFC_OP_TEST_CLEAR_SKIP)
    || (instr_op == CFC_OP_TEST_SET_SKIP);
  wire logic bit_ok = in_bit_ram(bit_addr);
  wire logic bit_val = bit_data[bit_sel];
  wire logic is_skip_op = (instr_op == CFC_OP_CMP_SKIP) || (instr_op == CFC_OP_INCDEC_SKIP)
    || (instr_op == CFC_OP_TEST_CLEAR_SKIP) || (instr_op == CFC_OP_TEST_SET_SKIP);
  wire logic skip_cond =
    ((instr_op == CFC_OP_CMP_SKIP) && (cmp_a == cmp_b)) ||
    ((instr_op == CFC_OP_INCDEC_SKIP) && (cmp_a == 8'h00)) ||
    ((instr_op == CFC_OP_TEST_CLEAR_SKIP) && bit_ok && !bit_val) ||
    ((instr_op == CFC_OP_TEST_SET_SKIP) && bit_ok && bit_val);
  wire logic is_two_op = (instr_op == CFC_OP_JUMP) || (instr_op == CFC_OP_CALL) || (instr_op == CFC_OP_IDX)
    || (instr_op == CFC_OP_PCADD) || (instr_op == CFC_OP_RET) || (instr_op == CFC_OP_RETI);
  wire logic take = instr_valid && (state_reg == CFC_S_FIRST);
  wire logic two_cyc = is_two_op || (is_skip_op && skip_cond);

  // flag mask per instruction class
  logic [3:0] mask_sel;
  always_comb begin
    unique case (instr_op)
      CFC_OP_ARITH, CFC_OP_FLAG_POP, CFC_OP_CMP_SKIP, CFC_OP_INCDEC_SKIP: mask_sel = CFC_MASK_ALL;
      CFC_OP_LOGIC: mask_sel = CFC_MASK_ZERO;
      CFC_OP_SHIFT: mask_sel = CFC_MASK_CARRY;
      default: mask_sel = CFC_MASK_NONE;
    endcase
  end

  assign fl.upd = take;
  assign fl.mask = mask_sel;
  assign fl.value = alu_flags;

  // sequencer next state
  assign state_next = (take && two_cyc) ? CFC_S_SECOND : CFC_S_FIRST;

  // stack and program counter next values
  wire logic do_call = take && (instr_op == CFC_OP_CALL);
  wire logic do_ret = take && ((instr_op == CFC_OP_RET) || (instr_op == CFC_OP_RETI));
  wire logic [7:0] sp_next = do_call ? stack_pointer + CFC_SP_STEP
    : (do_ret ? stack_pointer - CFC_SP_STEP : stack_pointer);
  wire logic [PC_W-1:0] ret_pc = pc_cur + {{(PC_W-1){1'b0}}, 1'b1};
  wire logic load_pc = do_call || do_ret || (take && (instr_op == CFC_OP_JUMP));
  wire logic [PC_W-1:0] pc_target = do_ret ? stack_pc : target_pc;
  wire logic gie_next = (take && (instr_op == CFC_OP_RETI)) ? 1'b1
    : (gie_set ? 1'b1 : (gie_clr ? 1'b0 : gie));

  // sequencer state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= CFC_S_FIRST;
    end else begin
      state_reg <= state_next;
    end
  end

  // timing outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cycles <= CFC_CYC_ONE;
      skip_next <= 1'b0;
      bit_err <= 1'b0;
    end else begin
      busy <= take && two_cyc;
      cycles <= take ? (two_cyc ? CFC_CYC_TWO : CFC_CYC_ONE) : cycles;
      skip_next <= take && is_skip_op && skip_cond;
      bit_err <= take && is_bit_op && !bit_ok;
    end
  end

  // stack pointer, stack write and pc load
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stack_pointer <= CFC_SP_RST;
      stack_we <= 1'b0;
      stack_addr <= CFC_SP_RST;
      stack_wdata <= '0;
      pc_load <= 1'b0;
      pc_new <= '0;
    end else begin
      stack_pointer <= sp_next;
      stack_we <= do_call;
      stack_addr <= do_ret ? stack_pointer - CFC_SP_STEP : stack_pointer;
      stack_wdata <= ret_pc;
      pc_load <= load_pc;
      pc_new <= pc_target;
    end
  end

  // global interrupt enable and flags copy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gie <= 1'b0;
      flags <= CFC_FLAGS_RST;
    end else begin
      gie <= gie_next;
      flags <= fl.flags;
    end
  end

  chk_two_cycle_ops: assert property (@(posedge mclk) disable iff (rst)
    (take && is_two_op) |=> (busy && cycles == CFC_CYC_TWO && !fl.upd))
    else $error("two cycle op not held");
  chk_skip_taken: assert property (@(posedge mclk) disable iff (rst)
    (take && is_skip_op && skip_cond) |=> (skip_next && busy))
    else $error("taken skip not two cycles");
  chk_skip_not_taken: assert property (@(posedge mclk) disable iff (rst)
    (take && is_skip_op && !skip_cond) |=> (!skip_next && !busy && cycles == CFC_CYC_ONE))
    else $error("untaken skip not one cycle");
  chk_arith_flags: assert property (@(posedge mclk) disable iff (rst)
    (take && instr_op == CFC_OP_ARITH) |=> ##1 (flags == $past(alu_flags, 2)))
    else $error("arith flags not updated");
  chk_bit_range: assert property (@(posedge mclk) disable iff (rst)
    (take && is_bit_op && bit_addr > CFC_BIT_RAM_HI) |=> bit_err)
    else $error("out of range bit access not flagged");
  chk_shift_flags: assert property (@(posedge mclk) disable iff (rst)
    (take && instr_op == CFC_OP_SHIFT) |=> (fl.flags[CFC_ZERO_BIT] == $past(fl.flags[CFC_ZERO_BIT])))
    else $error("shift changed zero");
  chk_call_stack: assert property (@(posedge mclk) disable iff (rst)
    (take && instr_op == CFC_OP_CALL) |=> (stack_we && stack_pointer == $past(stack_pointer) + CFC_SP_STEP
      && stack_wdata == $past(pc_cur) + 1'b1))
    else $error("call stack wrong");
  chk_reti_gie: assert property (@(posedge mclk) disable iff (rst)
    (take && instr_op == CFC_OP_RETI) |=> (gie && pc_load && pc_new == $past(stack_pc)))
    else $error("reti did not restore");

  // further guards on returns, busy length, flag masks and the bit window
  chk_ret_stack: assert property (@(posedge mclk) disable iff (rst)
    (take && instr_op == CFC_OP_RET) |=> (pc_load && pc_new == $past(stack_pc)
      && stack_pointer == $past(stack_pointer) - CFC_SP_STEP))
    else $error("return did not restore pc");
  chk_busy_one_cycle: assert property (@(posedge mclk) disable iff (rst)
    busy |=> !busy)
    else $error("busy held beyond second cycle");
  chk_skip_flags: assert property (@(posedge mclk) disable iff (rst)
    (take && instr_op == CFC_OP_INCDEC_SKIP) |=> (fl.flags == $past(alu_flags)))
    else $error("skip op flags not updated");
  chk_logic_flags: assert property (@(posedge mclk) disable iff (rst)
    (take && instr_op == CFC_OP_LOGIC) |=> (fl.flags[CFC_ZERO_BIT] == $past(alu_flags[CFC_ZERO_BIT])
      && fl.flags[CFC_CARRY_BIT] == $past(fl.flags[CFC_CARRY_BIT])))
    else $error("logic op flags wrong");
  chk_bit_no_flags: assert property (@(posedge mclk) disable iff (rst)
    (take && instr_op == CFC_OP_BIT_MEM) |=> (fl.flags == $past(fl.flags)))
    else $error("bit op changed flags");
  chk_bit_in_range: assert property (@(posedge mclk) disable iff (rst)
    (take && is_bit_op && bit_addr <= CFC_BIT_RAM_HI) |=> !bit_err)
    else $error("in range bit access flagged");

  cov_skip: cover property (@(posedge mclk) disable iff (rst) take && is_skip_op && skip_cond);
  cov_call: cover property (@(posedge mclk) disable iff (rst) do_call);
  cov_reti: cover property (@(posedge mclk) disable iff (rst) take && instr_op == CFC_OP_RETI);
  // out of window bit access and a request refused in the busy cycle
  cov_bit_err: cover property (@(posedge mclk) disable iff (rst) take && is_bit_op && !bit_ok);
  cov_refused: cover property (@(posedge mclk) disable iff (rst) instr_valid && state_reg == CFC_S_SECOND);

endmodule : cfc_core_ctl

/* cpu_cycle_and_flag_control_tb.sv */
// self-checking bench for the cycle and flag control block
`timescale 1ns/10ps
module cpu_cycle_and_flag_control_tb;
  import cfc_pkg::*;
  logic mclk, rst, instr_valid, gie_set, gie_clr; // clock, reset and plain controls
  cfc_op_e instr_op; // instruction class under test
  logic [7:0] cmp_a, cmp_b, bit_addr, bit_data; // operands and bit byte
  logic [2:0] bit_sel; // bit index
  logic [11:0] pc_cur, target_pc, stack_pc; // program counter inputs
  logic [3:0] alu_flags; // new flag values
  logic busy, skip_next, bit_err, stack_we, pc_load, gie; // design pulses and levels
  logic [1:0] cycles; // design cycle count
  logic [3:0] flags; // design flags
  logic [7:0] stack_addr, stack_pointer; // design stack outputs
  logic [11:0] stack_wdata, pc_new; // design pc outputs
  // model state, expected at the next check
  logic e_busy, e_sk, e_be, e_we, e_pl, e_gie, prev_two;
  logic [1:0] e_cyc;
  logic [7:0] e_sa, sp_m;
  logic [11:0] e_wd, e_pn;
  logic [3:0] fl_m, fl_d;
  int fail_count = 0; // mismatches seen
  int n_checks = 0; // comparisons made
  int seed = 32'h787eaa06; // fixed random seed

  cfc_core_ctl DUT (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op), .cmp_a(cmp_a),
    .cmp_b(cmp_b), .bit_addr(bit_addr), .bit_sel(bit_sel), .bit_data(bit_data), .pc_cur(pc_cur),
    .target_pc(target_pc), .stack_pc(stack_pc), .alu_flags(alu_flags), .gie_set(gie_set), .gie_clr(gie_clr),
    .busy(busy), .cycles(cycles), .skip_next(skip_next), .bit_err(bit_err), .flags(flags), .stack_we(stack_we),
    .stack_addr(stack_addr), .stack_wdata(stack_wdata), .stack_pointer(stack_pointer), .pc_load(pc_load),
    .pc_new(pc_new), .gie(gie));

  // compare one value and count it
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // print the counts and the verdict, then stop
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // clear the model to its reset values
  task automatic model_reset();
    {e_busy, e_sk, e_be, e_we, e_pl, e_gie, prev_two} = 7'h00;
    e_cyc = CFC_CYC_ONE;
    e_sa = CFC_SP_RST;
    sp_m = CFC_SP_RST;
    fl_m = CFC_FLAGS_RST;
    fl_d = CFC_FLAGS_RST;
  endtask : model_reset

  // check last issue at the falling edge, then drive and predict a new one
  task automatic step(input logic v, input logic [4:0] k);
    logic [31:0] r1, r2, r3;
    logic [3:0] m;
    logic two, take, in_rng;
    @(negedge mclk);
    chk(16'(busy), 16'(e_busy));
    chk(16'(cycles), 16'(e_cyc));
    chk(16'(skip_next), 16'(e_sk));
    chk(16'(bit_err), 16'(e_be));
    chk(16'(flags), 16'(fl_d));
    chk(16'(stack_we), 16'(e_we));
    chk(16'(stack_pointer), 16'(sp_m));
    chk(16'(pc_load), 16'(e_pl));
    chk(16'(gie), 16'(e_gie));
    chk(16'(stack_addr), 16'(e_sa));
    if (e_we) chk(16'(stack_wdata), 16'(e_wd));
    if (e_pl) chk(16'(pc_new), 16'(e_pn));
    fl_d = fl_m;
    r1 = $random(seed);
    r2 = $random(seed);
    r3 = $random(seed);
    // drive fresh operands; zero and equal operands are favoured so skips fire
    instr_valid = v;
    instr_op = cfc_op_e'(k[4] ? {1'b0, r1[3:0]} : k);
    cmp_a = r1[4] ? 8'h00 : r1[12:5];
    cmp_b = r1[13] ? cmp_a : r1[21:14];
    bit_addr = r2[7:0];
    bit_sel = r2[10:8];
    bit_data = r2[18:11];
    alu_flags = r2[22:19];
    gie_set = (r2[24:23] == 2'h0);
    gie_clr = !gie_set && (r2[26:25] == 2'h0);
    pc_cur = r3[11:0];
    target_pc = r3[23:12];
    stack_pc = {r3[31:24], r1[31:28]};
    // a request in the busy cycle is ignored
    take = v && !prev_two;
    in_rng = (bit_addr <= CFC_BIT_RAM_HI);
    {two, e_sk, e_be, e_we, e_pl} = 5'h00;
    m = CFC_MASK_NONE;
    e_sa = sp_m;
    if (take) begin
      case (instr_op)
        CFC_OP_JUMP, CFC_OP_CALL, CFC_OP_IDX, CFC_OP_PCADD, CFC_OP_RET, CFC_OP_RETI: two = 1'b1;
        CFC_OP_CMP_SKIP: {e_sk, m} = {cmp_a == cmp_b, CFC_MASK_ALL};
        CFC_OP_INCDEC_SKIP: {e_sk, m} = {cmp_a == 8'h00, CFC_MASK_ALL};
        CFC_OP_TEST_CLEAR_SKIP: {e_sk, e_be} = {in_rng && !bit_data[bit_sel], !in_rng};
        CFC_OP_TEST_SET_SKIP: {e_sk, e_be} = {in_rng && bit_data[bit_sel], !in_rng};
        CFC_OP_BIT_MEM: e_be = !in_rng;
        CFC_OP_ARITH, CFC_OP_FLAG_POP: m = CFC_MASK_ALL;
        CFC_OP_LOGIC: m = CFC_MASK_ZERO;
        CFC_OP_SHIFT: m = CFC_MASK_CARRY;
        default: m = CFC_MASK_NONE;
      endcase
      two = two | e_sk;
      e_cyc = two ? CFC_CYC_TWO : CFC_CYC_ONE;
      fl_m = (fl_m & ~m) | (alu_flags & m);
      // stack and program counter effects of calls and returns
      if (instr_op == CFC_OP_CALL) begin
        {e_we, e_pl, e_sa, e_wd, e_pn} = {2'h3, sp_m, pc_cur + 12'h001, target_pc};
        sp_m = sp_m + CFC_SP_STEP;
      end
      if (instr_op == CFC_OP_JUMP) {e_pl, e_pn} = {1'b1, target_pc};
      if (instr_op == CFC_OP_RET || instr_op == CFC_OP_RETI) begin
        {e_pl, e_pn} = {1'b1, stack_pc};
        e_sa = sp_m - CFC_SP_STEP;
        sp_m = sp_m - CFC_SP_STEP;
      end
    end
    // global enable: interrupt return wins over the clear pulse
    if (take && instr_op == CFC_OP_RETI) e_gie = 1'b1;
    else if (gie_set) e_gie = 1'b1;
    else if (gie_clr) e_gie = 1'b0;
    e_busy = two;
    prev_two = two;
  endtask : step

  // free running clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // hang guard
  initial begin
    #200000;
    fail_count++;
    conclude();
  end

  // two passes, the second after a reset in mid-run
  initial begin
    {rst, instr_valid, gie_set, gie_clr} = 4'h8;
    instr_op = CFC_OP_OTHER;
    {cmp_a, cmp_b, bit_addr, bit_data, bit_sel, alu_flags} = 39'h0;
    {pc_cur, target_pc, stack_pc} = 36'h0;
    for (int p = 0; p < 2; p++) begin
      rst = 1'b1;
      {instr_valid, gie_set, gie_clr} = 3'h0;
      model_reset();
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      for (int i = 0; i < 600; i++) begin
        step(prev_two ? (($random(seed) & 7) == 0) : 1'b1, (i < 16) ? 5'(i) : 5'h10);
      end
      $display("pass %0d done, checks %0d", p, n_checks);
    end
    conclude();
  end
endmodule : cpu_cycle_and_flag_control_tb
